// [hdl/serial_host_pkg.sv]
// shared constants and carrier types for the serial host port selector
package serial_host_pkg;

  // clock rate and reset pulse length
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // synchroniser depth and settle time before the strap is caught
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

  // pin counts
  localparam int GPIO_COUNT = 4;
  localparam int ADDR_SEL_WIDTH = 2;

  // reset and idle levels of pins
  localparam logic TXD_IDLE = 1'b0;
  localparam logic OD_PULL_LEVEL = 1'b0;
  localparam logic SCL_I2C_IDLE = 1'b1;
  localparam logic CS_IDLE = 1'b1;
  localparam logic STRAP_RESET = 1'b1;
  localparam logic GPIO_DIR_OUTPUT = 1'b1;

  // strap levels
  localparam logic STRAP_I2C = 1'b1;

  // selected host interface
  typedef enum logic [1:0]
  {
    MODE_WAIT = 2'b00,
    MODE_I2C = 2'b01,
    MODE_SPI = 2'b10
  } host_mode_e;

  // two-wire view of the shared pins
  typedef struct packed
  {
    logic active;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [ADDR_SEL_WIDTH-1:0] base_addr_sel;
  } i2c_side_s;

  // four-wire view of the shared pins
  typedef struct packed
  {
    logic active;
    logic selected;
    logic si;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
  } spi_side_s;

endpackage

// [hdl/bit_sync.sv]
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous input and synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  // first stage feeds only the second stage
  always_comb
  begin
    meta_d = async_in;
    stable_d = meta_q;
  end

  // register both stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RESET_VAL;
      stable_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_out = stable_q;

endmodule

// [hdl/gpio_cell.sv]
// one general-purpose pin with direction control and input synchroniser
`timescale 1ns/1ps
module gpio_cell (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core side
  input wire logic dir_out,
  input wire logic out_value,
  output logic in_value,
  // pin side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  import serial_host_pkg::*;

  logic [1:0] in_sync_q;
  logic [1:0] in_sync_d;
  logic pin_out_q;
  logic pin_out_d;
  logic pin_oe_q;
  logic pin_oe_d;

  // drive only when the direction bit says output
  always_comb
  begin
    in_sync_d = {in_sync_q[0], pin_in};
    pin_out_d = out_value;
    pin_oe_d = (dir_out == GPIO_DIR_OUTPUT);
  end

  // pins float during reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_sync_q <= 2'h0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      in_sync_q <= in_sync_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign in_value = in_sync_q[1];
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

endmodule

// [hdl/serial_host_port_select.sv]
// pin multiplexer between two-wire and four-wire host interfaces of a uart bridge
//
// Overview of operation
// R1: strap high selects two-wire target, strap low selects four-wire target
// R2: host idles the shared clock high in two-wire mode
// R3: host idles the shared clock low in four-wire mode
// R4: reset low longer than 40 ns clears all registers and outputs; strap, host pin and edge registers reset to idle levels instead
// R5: during reset transmit stays idle and receive input is ignored
// R6: interrupt output only pulls low, signalling a pending interrupt
// R7: in two-wire mode the address selects modify the base address
// R8: in four-wire mode select zero is active-low chip select gating transactions
// R9: in four-wire mode select one carries serial input data
// R10: four-wire serial output is tri-state, driven only when returning data
// R11: two-wire data line is open-drain, only pulled low or released
// R12: four general pins, each input or output by its direction bit
// R13: transmit output is low during reset and while idle
// R14: strap is static; the unselected interface ignores shared pin activity
// R15: serial output floats while chip select is high or two-wire selected
`timescale 1ns/1ps
module serial_host_port_select (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // protocol strap
  input wire logic PROTO_SEL,
  // shared host pins
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDRESS_SELECT_0,
  input wire logic ADDRESS_SELECT_1,
  output logic SO_OUT,
  output logic SO_OE,
  // interrupt pin
  output logic IRQ_B_OUT,
  output logic IRQ_B_OE,
  // uart pins
  output logic TXD,
  input wire logic RXD,
  // general-purpose pins
  input wire logic [serial_host_pkg::GPIO_COUNT-1:0] GPIO_IN,
  output logic [serial_host_pkg::GPIO_COUNT-1:0] GPIO_OUT,
  output logic [serial_host_pkg::GPIO_COUNT-1:0] GPIO_OE,
  // protocol engine side
  output serial_host_pkg::host_mode_e MODE,
  output serial_host_pkg::i2c_side_s I2C_SIDE,
  output serial_host_pkg::spi_side_s SPI_SIDE,
  input wire logic SDA_PULL_LOW,
  input wire logic SO_DRIVE,
  input wire logic SO_BIT,
  // uart core side
  input wire logic IRQ_PENDING,
  input wire logic TX_ACTIVE,
  input wire logic TX_BIT,
  output logic RX_BIT,
  // gpio core side
  input wire logic [serial_host_pkg::GPIO_COUNT-1:0] PIN_DIRECTION_REG,
  input wire logic [serial_host_pkg::GPIO_COUNT-1:0] GPIO_OUT_VALUE,
  output logic [serial_host_pkg::GPIO_COUNT-1:0] GPIO_IN_VALUE
);
  import serial_host_pkg::*;

  // reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_n;

  // synchronised pin levels
  logic strap_s;
  logic scl_s;
  logic sda_s;
  logic sel0_s;
  logic sel1_s;
  logic rxd_s;

  // mode capture state
  host_mode_e mode_q;
  host_mode_e mode_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;

  // previous pin levels for edge detection
  logic scl_prev_q;
  logic scl_prev_d;
  logic sda_prev_q;
  logic sda_prev_d;
  logic cs_prev_q;
  logic cs_prev_d;

  // registered engine-side views
  i2c_side_s i2c_q;
  i2c_side_s i2c_d;
  spi_side_s spi_q;
  spi_side_s spi_d;

  // registered pin drivers
  logic sda_out_q;
  logic sda_out_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic so_out_q;
  logic so_out_d;
  logic so_oe_q;
  logic so_oe_d;
  logic irq_out_q;
  logic irq_out_d;
  logic irq_oe_q;
  logic irq_oe_d;
  logic txd_q;
  logic txd_d;
  logic rx_q;
  logic rx_d;

  // asynchronous assert, two-flop release
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rst_sync_q <= 2'h0; // R4
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // synchronise the strap
  bit_sync #(
    .WIDTH(1),
    .RESET_VAL(STRAP_RESET)
  ) u_strap_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .async_in(PROTO_SEL),
    .sync_out(strap_s)
  );

  // synchronise the shared host pins
  bit_sync #(
    .WIDTH(4),
    .RESET_VAL({SCL_I2C_IDLE, 1'b1, CS_IDLE, 1'b0})
  ) u_host_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .async_in({SCL, SDA_IN, ADDRESS_SELECT_0, ADDRESS_SELECT_1}),
    .sync_out({scl_s, sda_s, sel0_s, sel1_s})
  );

  // synchronise the uart receive pin
  bit_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_rxd_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .async_in(RXD),
    .sync_out(rxd_s)
  );

  // catch the strap once the synchronisers have settled, then hold it
  always_comb
  begin
    mode_d = mode_q;
    settle_d = settle_q;
    if (mode_q == MODE_WAIT)
    begin
      if (settle_q == SETTLE_CYCLES)
        mode_d = (strap_s == STRAP_I2C) ? MODE_I2C : MODE_SPI; // R1 R14
      else
        settle_d = settle_q + 2'h1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_WAIT;
      settle_q <= 2'h0;
    end
    else
    begin
      mode_q <= mode_d;
      settle_q <= settle_d;
    end
  end

  // remember previous levels of clock, data and select
  always_comb
  begin
    scl_prev_d = scl_s;
    sda_prev_d = sda_s;
    cs_prev_d = sel0_s;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_prev_q <= SCL_I2C_IDLE;
      sda_prev_q <= 1'b1;
      cs_prev_q <= CS_IDLE;
    end
    else
    begin
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      cs_prev_q <= cs_prev_d;
    end
  end

  // two-wire view, quiet unless two-wire mode is selected
  always_comb
  begin
    i2c_d = '0;
    if (mode_q == MODE_I2C) // R14
    begin
      i2c_d.active = 1'b1;
      i2c_d.scl = scl_s; // R2
      i2c_d.sda = sda_s;
      i2c_d.scl_rise = scl_s & ~scl_prev_q;
      i2c_d.scl_fall = ~scl_s & scl_prev_q;
      i2c_d.start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
      i2c_d.stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
      i2c_d.base_addr_sel = {sel1_s, sel0_s}; // R7
    end
  end

  // four-wire view, clock edges only while chip select is low
  always_comb
  begin
    spi_d = '0;
    if (mode_q == MODE_SPI) // R14
    begin
      spi_d.active = 1'b1;
      spi_d.selected = ~sel0_s; // R8
      spi_d.si = sel1_s; // R9
      spi_d.sclk_rise = ~sel0_s & scl_s & ~scl_prev_q; // R3 R8
      spi_d.sclk_fall = ~sel0_s & ~scl_s & scl_prev_q; // R3 R8
      spi_d.cs_fall = cs_prev_q & ~sel0_s;
      spi_d.cs_rise = ~cs_prev_q & sel0_s;
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i2c_q <= '0;
      spi_q <= '0;
    end
    else
    begin
      i2c_q <= i2c_d;
      spi_q <= spi_d;
    end
  end

  // open-drain data line and tri-state serial output
  always_comb
  begin
    sda_out_d = OD_PULL_LEVEL; // R11
    sda_oe_d = (mode_q == MODE_I2C) & SDA_PULL_LOW; // R11 R14
    so_out_d = SO_BIT;
    so_oe_d = (mode_q == MODE_SPI) & ~sel0_s & SO_DRIVE; // R10 R15
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out_q <= OD_PULL_LEVEL;
      sda_oe_q <= 1'b0;
      so_out_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else
    begin
      sda_out_q <= sda_out_d;
      sda_oe_q <= sda_oe_d;
      so_out_q <= so_out_d;
      so_oe_q <= so_oe_d;
    end
  end

  // open-drain interrupt, uart transmit and receive
  always_comb
  begin
    irq_out_d = OD_PULL_LEVEL; // R6
    irq_oe_d = IRQ_PENDING; // R6
    txd_d = TX_ACTIVE ? TX_BIT : TXD_IDLE; // R13
    rx_d = rxd_s;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_out_q <= OD_PULL_LEVEL;
      irq_oe_q <= 1'b0;
      txd_q <= TXD_IDLE; // R5 R13
      rx_q <= 1'b0; // R5
    end
    else
    begin
      irq_out_q <= irq_out_d;
      irq_oe_q <= irq_oe_d;
      txd_q <= txd_d;
      rx_q <= rx_d;
    end
  end

  // general-purpose pins, one cell each
  for (genvar i = 0; i < GPIO_COUNT; i++)
  begin : g_gpio
    gpio_cell u_cell (
      .clk(CLK),
      .rst_n(rst_n),
      .dir_out(PIN_DIRECTION_REG[i]), // R12
      .out_value(GPIO_OUT_VALUE[i]),
      .in_value(GPIO_IN_VALUE[i]),
      .pin_in(GPIO_IN[i]),
      .pin_out(GPIO_OUT[i]),
      .pin_oe(GPIO_OE[i])
    );
  end

  // output drivers
  assign MODE = mode_q;
  assign I2C_SIDE = i2c_q;
  assign SPI_SIDE = spi_q;
  assign SDA_OUT = sda_out_q;
  assign SDA_OE = sda_oe_q;
  assign SO_OUT = so_out_q;
  assign SO_OE = so_oe_q;
  assign IRQ_B_OUT = irq_out_q;
  assign IRQ_B_OE = irq_oe_q;
  assign TXD = txd_q;
  assign RX_BIT = rx_q;

endmodule

// [dv/serial_host_port_select_sva.sv]
// port assertions for the serial host pin multiplexer
`timescale 1ns/1ps
module serial_host_port_select_sva
  import serial_host_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // pin outputs
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic SO_OE,
  input wire logic IRQ_B_OUT,
  input wire logic IRQ_B_OE,
  input wire logic TXD,
  // engine and core side
  input wire host_mode_e MODE,
  input wire i2c_side_s I2C_SIDE,
  input wire spi_side_s SPI_SIDE,
  input wire logic SDA_PULL_LOW,
  input wire logic SO_DRIVE,
  input wire logic IRQ_PENDING,
  input wire logic TX_ACTIVE,
  input wire logic TX_BIT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // open-drain pins never drive high
  property p_od_low; SDA_OUT == 1'b0 && IRQ_B_OUT == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");
  property p_irq; $past(MODE) != MODE_WAIT |-> IRQ_B_OE == $past(IRQ_PENDING); endproperty
  a_irq: assert property (p_irq) else $error("interrupt pull wrong");
  property p_txd; $past(MODE) != MODE_WAIT |-> TXD == ($past(TX_ACTIVE) & $past(TX_BIT)); endproperty
  a_txd: assert property (p_txd) else $error("transmit not idle low");
  property p_sda_oe; SDA_OE |-> MODE == MODE_I2C && $past(SDA_PULL_LOW); endproperty
  a_sda_oe: assert property (p_sda_oe) else $error("data line pulled wrongly");
  property p_so_oe; SO_OE |-> MODE == MODE_SPI && $past(SO_DRIVE); endproperty
  a_so_oe: assert property (p_so_oe) else $error("serial out driven wrongly");
  property p_mode_hold; MODE != MODE_WAIT |=> MODE == $past(MODE); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
  property p_sclk_gate; SPI_SIDE.sclk_rise || SPI_SIDE.sclk_fall |-> SPI_SIDE.selected; endproperty
  a_sclk_gate: assert property (p_sclk_gate) else $error("clock edge while unselected");
  property p_quiet; (MODE == MODE_SPI || SPI_SIDE == '0) && (MODE == MODE_I2C || I2C_SIDE == '0); endproperty
  a_quiet: assert property (p_quiet) else $error("unselected view active");
endmodule
bind serial_host_port_select serial_host_port_select_sva u_sva (.CLK(CLK), .RST_B(RST_B), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .SO_OE(SO_OE), .IRQ_B_OUT(IRQ_B_OUT), .IRQ_B_OE(IRQ_B_OE), .TXD(TXD), .MODE(MODE),
  .I2C_SIDE(I2C_SIDE), .SPI_SIDE(SPI_SIDE), .SDA_PULL_LOW(SDA_PULL_LOW), .SO_DRIVE(SO_DRIVE),
  .IRQ_PENDING(IRQ_PENDING), .TX_ACTIVE(TX_ACTIVE), .TX_BIT(TX_BIT));

// [dv/host_model.sv]
// host master model on the shared serial pins
`timescale 1ns/1ps
module host_model (
  // mode and open-drain pull from the device
  input wire logic i2c,
  input wire logic sda_oe,
  // shared pins
  output logic scl,
  output logic sda_in,
  output logic sel0,
  output logic sel1
);
  logic sda_drv = 1'b1;
  initial
  begin
    scl = 1'b1;
    sel0 = 1'b1;
    sel1 = 1'b0;
  end
  // pulled-up line, low when either side pulls
  assign sda_in = sda_drv & ~sda_oe;
  // clock stands at its idle level outside frames
  task automatic idle();
    scl = i2c;
  endtask
  task automatic select(input logic lvl);
    sel0 = lvl;
  endtask
  // one byte msb first, 200 ns per bit, data moves only while the clock is low, except the two-wire release after the last bit
  task automatic frame(input logic [7:0] b, input logic cs);
    int i;
    sel0 = cs;
    #100;
    for (i = 7; i >= 0; i--)
    begin
      if (i2c)
      begin
        scl = 1'b0;
        #50;
        sda_drv = b[i];
        #50;
        scl = 1'b1;
        #100;
      end
      else
      begin
        sel1 = b[i];
        #100;
        scl = 1'b1;
        #100;
        scl = 1'b0;
      end
    end
    #100;
    sda_drv = 1'b1;
    sel0 = 1'b1;
    sel1 = ~sel1;
  endtask
endmodule

// [dv/serial_host_port_select_bench.sv]
// self-checking bench for the serial host pin multiplexer
`timescale 1ns/1ps
module serial_host_port_select_bench;
  import serial_host_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic proto = 1'b1;
  logic rxd = 1'b0;
  logic scl, sda_in, sel0, sel1, sda_out, sda_oe, so_out, so_oe, irq_out, irq_oe, txd, rx_bit;
  wire irq, tx_act, tx_bit, pull, so_drv, so_bit;
  wire [3:0] dir, outv, gin;
  logic [3:0] gout, goe, ginv;
  logic [17:0] drv = 18'h0;
  logic [17:0] h;
  logic [17:0] hq[$];
  logic rq[$];
  host_mode_e mode;
  i2c_side_s i2c_s;
  spi_side_s spi_s;
  int failures = 0, compares = 0, cycles = 0, rises = 0, pass, k, seed;
  logic chk_on = 1'b0;
  assign {irq, tx_act, tx_bit, pull, so_drv, so_bit, dir, outv, gin} = drv;
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  serial_host_port_select u_dut (.CLK(clk), .RST_B(rst_b), .PROTO_SEL(proto), .SCL(scl), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDRESS_SELECT_0(sel0), .ADDRESS_SELECT_1(sel1), .SO_OUT(so_out),
    .SO_OE(so_oe), .IRQ_B_OUT(irq_out), .IRQ_B_OE(irq_oe), .TXD(txd), .RXD(rxd), .GPIO_IN(gin),
    .GPIO_OUT(gout), .GPIO_OE(goe), .MODE(mode), .I2C_SIDE(i2c_s), .SPI_SIDE(spi_s), .SDA_PULL_LOW(pull),
    .SO_DRIVE(so_drv), .SO_BIT(so_bit), .IRQ_PENDING(irq), .TX_ACTIVE(tx_act), .TX_BIT(tx_bit),
    .RX_BIT(rx_bit), .PIN_DIRECTION_REG(dir), .GPIO_OUT_VALUE(outv), .GPIO_IN_VALUE(ginv));
  host_model u_host (.i2c(proto), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in), .sel0(sel0), .sel1(sel1));
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // cycle ceiling and edge counter
  always @(posedge clk)
  begin
    cycles++;
    if (i2c_s.scl_rise === 1'b1 || spi_s.sclk_rise === 1'b1)
      rises++;
    if (cycles == 5000)
    begin
      failures++;
      close_out();
    end
  end
  // model compare, then random drive
  always @(negedge clk)
  begin
    if (chk_on && hq.size() > 1)
    begin
      h = hq[$];
      chk("txd", {3'h0, h[16] & h[15]}, {3'h0, txd});
      chk("irq_oe", {3'h0, h[17]}, {3'h0, irq_oe});
      chk("sda_oe", {3'h0, proto & h[14]}, {3'h0, sda_oe});
      chk("so_oe", {3'h0, !proto & !sel0 & h[13]}, {3'h0, so_oe});
      if (!proto && !sel0 && h[13])
        chk("so_out", {3'h0, h[12]}, {3'h0, so_out});
      chk("goe", h[11:8], goe);
      chk("gout", h[7:4], gout);
      chk("ginv", hq[$-1][3:0], ginv);
    end
    if (chk_on && rq.size() > 2)
      chk("rx_bit", {3'h0, rq[$-2]}, {3'h0, rx_bit});
    if (chk_on)
    begin
      drv = 18'($urandom);
      rxd = 1'($urandom);
      hq.push_back(drv);
      rq.push_back(rxd);
    end
  end
  initial
  begin
    seed = $urandom(32'hca4acab5);
    for (pass = 0; pass < 2; pass++)
    begin
      proto = (pass == 0);
      repeat (6) @(negedge clk);
      u_host.idle();
      rst_b = 1'b1;
      repeat (10) @(negedge clk);
      chk("mode", {2'h0, proto ? MODE_I2C : MODE_SPI}, {2'h0, mode});
      for (k = 0; k < 2; k++)
      begin
        rises = 0;
        u_host.frame(8'($urandom), k[0]);
        repeat (6) @(negedge clk);
        chk("rises", (proto || k == 0) ? 4'h8 : 4'h0, rises[3:0]);
      end
      if (proto)
        chk("addr", {2'h0, sel1, sel0}, {2'h0, i2c_s.base_addr_sel});
      else
        chk("si", {3'h0, sel1}, {3'h0, spi_s.si});
      u_host.select(1'($urandom));
      repeat (4) @(negedge clk);
      chk_on = 1'b1;
      repeat (200) @(negedge clk);
      chk_on = 1'b0;
      rst_b = 1'b0;
      @(negedge clk);
      chk("rst_out", 4'h0, {txd, irq_oe, sda_oe, so_oe});
      chk("rst_rx", 4'h0, {goe[2:0], rx_bit});
      chk("rst_mode", 4'h0, {2'h0, mode});
      chk("rst_goe", 4'h0, goe);
      chk("rst_view", 4'h0, {3'h0, |{i2c_s, spi_s, so_out, gout, ginv}});
      hq.delete();
      rq.delete();
    end
    close_out();
  end
endmodule
